/* File: sim/serial_port_config_relay_select_test.sv */
// Purpose: Self-checking bench for the serial port config and relay select block
// Assumes: Zero-wait APB slave
// Notes:   Pulse output checked for its start and queueing only, a full 100 ms period is too long to run
`timescale 1ns/1ps
`include "spcr_defs.svh"
module serial_port_config_relay_select_test;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  spcr_pkg::spcr_evt_t events;
  spcr_pkg::spcr_cmd_t cmd;
  logic                cmd_execute;
  logic                cmd_reply;
  logic                mb_rtu_only;
  logic [1:0]          port_mode;
  logic [2:0]          port_baud;
  logic                line_terminator;
  logic [7:0]          mb_id;
  logic [2:0]          mb_baud;
  logic [1:0]          mb_parity;
  logic                mb_stop2;
  logic                solid_state_switch_output;
  logic [31:0]         rd;
  logic                slv_err;
  int                  error_cnt;
  int                  comparisons;
  logic [31:0]         rst_v [4] = '{32'h30, 32'h11, 32'h430b, 32'h0};
  logic [31:0]         pt_w [3] = '{32'h101, 32'h172, 32'h63};
  logic [31:0]         pt_r [3] = '{32'h1, 32'h172, 32'h62};
  logic [31:0]         mb_w [4] = '{32'h10f7, 32'h62f8, 32'h3700, 32'h1};
  logic [31:0]         mb_r [4] = '{32'h10f7, 32'h62f7, 32'h27f7, 32'h1};
  spcr_pkg::spcr_evt_t pat [3] = '{10'h000, 10'h246, 10'h128};

  spcr_host host
  (
    .cmd  (cmd),
    .pclk (pclk)
  );

  spcr_top dut
  (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .events                    (events),
    .cmd                       (cmd),
    .cmd_execute               (cmd_execute),
    .cmd_reply                 (cmd_reply),
    .mb_rtu_only               (mb_rtu_only),
    .port_mode                 (port_mode),
    .port_baud                 (port_baud),
    .line_terminator           (line_terminator),
    .mb_id                     (mb_id),
    .mb_baud                   (mb_baud),
    .mb_parity                 (mb_parity),
    .mb_stop2                  (mb_stop2),
    .solid_state_switch_output (solid_state_switch_output)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // The whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ans(input logic [7:0] a, input int gap, input logic [1:0] exp);
    host.send(a, gap);
    #1;
    chk({30'h0, cmd_execute, cmd_reply}, {30'h0, exp});
  endtask

  function automatic logic rly(input logic [3:0] c, input spcr_pkg::spcr_evt_t e);
    logic [15:0] v;
    v = {1'b1, e.diag, |e[9:2], 1'b0, e.second_totalizer_limit, e.first_totalizer_limit,
         ~(e.tmp_lo | e.tmp_hi), e.tmp_hi, e.tmp_lo, ~(e.prs_lo | e.prs_hi), e.prs_hi, e.prs_lo,
         ~(e.flow_lo | e.flow_hi), e.flow_hi, e.flow_lo, 1'b0};
    return v[c];
  endfunction

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    events  = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_v[i])
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, rst_v[i]);
    end
    $display("test reset values done");
    foreach (pt_w[i])
    begin
      apb(1'b1, `SPCR_OFF_PORT, pt_w[i]);
      #1;
      chk({23'h0, line_terminator, 1'b0, port_baud, 2'h0, port_mode}, pt_r[i]);
    end
    foreach (mb_w[i])
    begin
      apb(1'b1, `SPCR_OFF_MB, mb_w[i]);
      apb(1'b0, `SPCR_OFF_MB, 32'h0);
      chk(rd, mb_r[i]);
      chk({17'h0, mb_stop2, mb_parity, 1'b0, mb_baud, mb_id}, mb_r[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `SPCR_OFF_PORT, 32'(i * 16 + 1));
      apb(1'b1, `SPCR_OFF_MB, 32'(i * 256 + 1));
      #1;
      chk({29'h0, port_baud}, 32'(i));
      chk({29'h0, mb_baud}, 32'(i));
    end
    $display("test settings done");
    foreach (pat[p])
    begin
      events <= pat[p];
      for (int c = 0; c < 16; c++)
      begin
        apb(1'b1, `SPCR_OFF_RELAY, 32'(c));
        repeat (4) @(posedge pclk);
        #1;
        chk({31'h0, solid_state_switch_output}, {31'h0, rly(4'(c), pat[p])});
      end
    end
    $display("test relay sources done");
    apb(1'b1, `SPCR_OFF_PORT, 32'h30);
    ans(8'h11, 0, 2'b00);
    apb(1'b1, `SPCR_OFF_PORT, 32'h31);
    ans(8'h5a, 3, 2'b11);
    apb(1'b1, `SPCR_OFF_PORT, 32'h32);
    apb(1'b1, `SPCR_OFF_ADDR, 32'h0);
    apb(1'b0, `SPCR_OFF_ADDR, 32'h0);
    chk(rd, 32'h11);
    apb(1'b1, `SPCR_OFF_ADDR, 32'h22);
    ans(8'h22, 0, 2'b11);
    ans(8'h11, 0, 2'b00);
    ans(8'h00, 0, 2'b10);
    $display("test command answers done");
    apb(1'b1, 12'h018, 32'hffff);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, slv_err}, 32'h1);
    $display("test unmapped done");
    // Run last: the pulse then holds the switch output high far beyond the end of the run
    apb(1'b1, `SPCR_OFF_RELAY, 32'h0);
    events <= 10'h001;
    repeat (4) @(posedge pclk);
    #1;
    chk({31'h0, solid_state_switch_output}, 32'h1);
    apb(1'b0, `SPCR_OFF_EVENTS, 32'h0);
    chk(rd, 32'h1);
    events <= 10'h000;
    repeat (4) @(posedge pclk);
    events <= 10'h001;
    repeat (4) @(posedge pclk);
    apb(1'b1, `SPCR_OFF_STATUS, 32'h1);
    apb(1'b0, `SPCR_OFF_STATUS, 32'h0);
    chk(rd, 32'h4);
    $display("test pulse queue done");
    wrap_up();
  end
endmodule

bind spcr_top spcr_chk u_chk
(
  .pclk            (pclk),
  .presetn         (presetn),
  .cmd             (cmd),
  .cmd_execute     (cmd_execute),
  .cmd_reply       (cmd_reply),
  .mb_rtu_only     (mb_rtu_only),
  .port_mode       (port_mode),
  .line_terminator (line_terminator),
  .mb_id           (mb_id),
  .mb_parity       (mb_parity)
);

/* File: sim/spcr_chk_properties.sv */
// Purpose: Command answer and setting range checks
// Assumes: One clock, bound to spcr_top
// Notes:   Bus address is internal, so address match is judged by the bench
`timescale 1ns/1ps
module spcr_chk
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire spcr_pkg::spcr_cmd_t cmd,
  input wire logic                cmd_execute,
  input wire logic                cmd_reply,
  input wire logic                mb_rtu_only,
  input wire logic [1:0]          port_mode,
  input wire logic                line_terminator,
  input wire logic [7:0]          mb_id,
  input wire logic [1:0]          mb_parity
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_mode_legal: assert property (port_mode != 2'h3)
    else $error("bad mode");
  chk_off_silent: assert property (cmd.valid && port_mode == 2'h0 |=> !cmd_execute && !cmd_reply)
    else $error("answer while off");
  chk_p2p_answers: assert property (cmd.valid && port_mode == 2'h1 |=> cmd_execute && cmd_reply)
    else $error("no answer in p2p");
  chk_bcast_quiet: assert property (cmd.valid && port_mode == 2'h2 && cmd.addr == 8'h00 |=> cmd_execute && !cmd_reply)
    else $error("bad broadcast");
  chk_answer_cause: assert property (cmd_execute |-> $past(cmd.valid))
    else $error("answer without frame");
  chk_term_bus: assert property (line_terminator |-> port_mode == 2'h2)
    else $error("termination outside bus mode");
  chk_id_range: assert property (mb_id >= 8'h01 && mb_id <= 8'hf7)
    else $error("id out of range");
  chk_parity_legal: assert property (mb_parity != 2'h3)
    else $error("bad parity");
  chk_rtu_only: assert property (mb_rtu_only)
    else $error("not rtu");
  cover property (cmd.valid && port_mode == 2'h2 ##1 cmd_reply);
  cover property (cmd_execute && !cmd_reply);
  cover property (line_terminator);
endmodule

/* File: sim/spcr_host.sv */
// Purpose: Serial master on the far side, hands frame addresses to the block
// Assumes: One address pulse per frame, same clock as the block
// Notes:   Address shows its inverse between frames, so a stale value is never read as live
`timescale 1ns/1ps
module spcr_host
(
  output spcr_pkg::spcr_cmd_t cmd,
  input  wire logic           pclk
);
  initial cmd = '{valid: 1'b0, addr: 8'h5a};
  // Callers keep 00 for broadcast and never give two devices one address
  task automatic send(input logic [7:0] a, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    cmd <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    cmd <= '{valid: 1'b0, addr: ~a};
  endtask
endmodule

/* File: src/spcr_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the serial port config block
// Assumes: APB slave at 250 MHz, one word per register
// Notes:   Definitions only
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

`define SPCR_OFF_PORT       12'h000
`define SPCR_OFF_ADDR       12'h004
`define SPCR_OFF_MB         12'h008
`define SPCR_OFF_RELAY      12'h00c
`define SPCR_OFF_EVENTS     12'h010
`define SPCR_OFF_STATUS     12'h014

`define SPCR_PORT_MODE_LSB  0
`define SPCR_PORT_BAUD_LSB  4
`define SPCR_PORT_TERM_BIT  8
`define SPCR_MB_ID_LSB      0
`define SPCR_MB_BAUD_LSB    8
`define SPCR_MB_PAR_LSB     12
`define SPCR_MB_STOP_BIT    14

`define SPCR_RST_MODE       2'h0
`define SPCR_RST_BAUD       3'h3
`define SPCR_RST_BUS_ADDR   8'h11
`define SPCR_RST_TERM       1'h0
`define SPCR_RST_MB_ID      8'h0b
`define SPCR_RST_MB_PAR     2'h0
`define SPCR_RST_MB_STOP    1'h1
`define SPCR_RST_RELAY      4'h0
`define SPCR_MB_ID_MIN      8'h01
`define SPCR_MB_ID_MAX      8'hf7
`define SPCR_BROADCAST      8'h00

`define SPCR_CLK_HZ         250000000
`define SPCR_PULSE_MS       100
`define SPCR_PULSE_CYC      (`SPCR_CLK_HZ / 1000 * `SPCR_PULSE_MS)
`define SPCR_QUEUE_MAX      16'hffff

`endif

/* File: src/spcr_pkg.sv */
// Purpose: Types for the serial port config and relay select block
// Assumes: Constants come from spcr_defs.svh
// Notes:   Types only
package spcr_pkg;

  typedef enum logic [1:0]
  {
    SPCR_MODE_OFF = 2'h0,
    SPCR_MODE_P2P = 2'h1,
    SPCR_MODE_BUS = 2'h2
  } spcr_mode_t;

  typedef enum logic [1:0]
  {
    SPCR_PAR_NONE = 2'h0,
    SPCR_PAR_ODD  = 2'h1,
    SPCR_PAR_EVEN = 2'h2
  } spcr_par_t;

  typedef enum logic [3:0]
  {
    SPCR_SRC_OFF     = 4'h0,
    SPCR_SRC_FLO_LO  = 4'h1,
    SPCR_SRC_FLO_HI  = 4'h2,
    SPCR_SRC_FLO_IN  = 4'h3,
    SPCR_SRC_PRS_LO  = 4'h4,
    SPCR_SRC_PRS_HI  = 4'h5,
    SPCR_SRC_PRS_IN  = 4'h6,
    SPCR_SRC_TMP_LO  = 4'h7,
    SPCR_SRC_TMP_HI  = 4'h8,
    SPCR_SRC_TMP_IN  = 4'h9,
    SPCR_SRC_TOT1    = 4'ha,
    SPCR_SRC_TOT2    = 4'hb,
    SPCR_SRC_PULSE   = 4'hc,
    SPCR_SRC_ALARM   = 4'hd,
    SPCR_SRC_DIAG    = 4'he,
    SPCR_SRC_MANUAL  = 4'hf
  } spcr_src_t;

  typedef enum logic [1:0]
  {
    SPCR_PLS_IDLE = 2'h0,
    SPCR_PLS_HIGH = 2'h1,
    SPCR_PLS_GAP  = 2'h3
  } spcr_pls_t;

  // Event inputs, synchronised before use
  typedef struct packed
  {
    logic flow_lo;
    logic flow_hi;
    logic prs_lo;
    logic prs_hi;
    logic tmp_lo;
    logic tmp_hi;
    logic first_totalizer_limit;
    logic second_totalizer_limit;
    logic diag;
    logic pulse_req;
  } spcr_evt_t;

  // Received frame address check
  typedef struct packed
  {
    logic       valid;
    logic [7:0] addr;
  } spcr_cmd_t;

  typedef struct packed
  {
    logic       execute;
    logic       reply;
  } spcr_dec_t;

  typedef struct packed
  {
    spcr_mode_t  mode;
    logic [2:0]  baud;
    logic [7:0]  bus_addr;
    logic        line_terminator;
    logic [7:0]  mb_id;
    logic [2:0]  mb_baud;
    spcr_par_t   mb_par;
    logic        mb_stop2;
    spcr_src_t   relay_src;
    logic [31:0] prdata;
    spcr_evt_t   evt_s1;
    spcr_evt_t   evt_s2;
    logic        pulse_req_prev;
    logic [15:0] queue;
    logic        queue_ovf;
    spcr_pls_t   pls;
    logic [24:0] pls_cnt;
    logic        pulse_out;
    logic        relay;
    spcr_dec_t   dec;
  } spcr_state_t;

endpackage

/* File: src/spcr_top.sv */
// Purpose: Serial port and Modbus settings, relay source selector and pulse output queue
// Assumes: APB master on pclk, event inputs asynchronous to pclk
// Notes:   Baud divisors are left to the UART that reads the rate codes
`timescale 1ns/1ps
`include "spcr_defs.svh"

module spcr_top
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire spcr_pkg::spcr_evt_t events,
  input  wire spcr_pkg::spcr_cmd_t cmd,
  output logic                   cmd_execute,
  output logic                   cmd_reply,
  output logic                   mb_rtu_only,
  output logic      [1:0]        port_mode,
  output logic      [2:0]        port_baud,
  output logic                   line_terminator,
  output logic      [7:0]        mb_id,
  output logic      [2:0]        mb_baud,
  output logic      [1:0]        mb_parity,
  output logic                   mb_stop2,
  output logic                   solid_state_switch_output
);

  localparam logic [24:0] PULSE_CYC = 25'(`SPCR_PULSE_CYC);

  spcr_pkg::spcr_state_t s_q;
  spcr_pkg::spcr_state_t s_d;
  logic                  wr;
  logic                  rd;
  logic                  hit;
  logic                  flo_in;
  logic                  prs_in;
  logic                  tmp_in;
  logic                  any_alarm;
  logic                  pulse_edge;
  spcr_pkg::spcr_evt_t   ev;

  assign hit = (paddr == `SPCR_OFF_PORT) || (paddr == `SPCR_OFF_ADDR) || (paddr == `SPCR_OFF_MB)
            || (paddr == `SPCR_OFF_RELAY) || (paddr == `SPCR_OFF_EVENTS) || (paddr == `SPCR_OFF_STATUS);
  assign wr  = psel && penable && pwrite && hit;
  assign rd  = psel && !penable && !pwrite;
  assign ev  = s_q.evt_s2;

  assign flo_in     = !ev.flow_lo && !ev.flow_hi;
  assign prs_in     = !ev.prs_lo && !ev.prs_hi;
  assign tmp_in     = !ev.tmp_lo && !ev.tmp_hi;
  assign any_alarm  = ev.flow_lo | ev.flow_hi | ev.prs_lo | ev.prs_hi | ev.tmp_lo | ev.tmp_hi
                    | ev.first_totalizer_limit | ev.second_totalizer_limit;
  assign pulse_edge = ev.pulse_req && !s_q.pulse_req_prev;

  always_comb
  begin
    s_d        = s_q;
    s_d.evt_s1 = events;
    s_d.evt_s2 = s_q.evt_s1;
    s_d.pulse_req_prev = ev.pulse_req;

    // Illegal codes are dropped so the field only ever holds a listed setting
    if (wr)
    begin
      unique case (paddr)
        `SPCR_OFF_PORT:
        begin
          if (pwdata[`SPCR_PORT_MODE_LSB +: 2] != 2'h3)
          begin
            s_d.mode = spcr_pkg::spcr_mode_t'(pwdata[`SPCR_PORT_MODE_LSB +: 2]);
          end
          s_d.baud = pwdata[`SPCR_PORT_BAUD_LSB +: 3];
          // Termination is refused outside multidrop to protect the transceiver
          s_d.line_terminator = pwdata[`SPCR_PORT_TERM_BIT]
                             && (pwdata[`SPCR_PORT_MODE_LSB +: 2] == spcr_pkg::SPCR_MODE_BUS);
        end
        `SPCR_OFF_ADDR:
        begin
          if (pwdata[7:0] != `SPCR_BROADCAST)
          begin
            s_d.bus_addr = pwdata[7:0];
          end
        end
        `SPCR_OFF_MB:
        begin
          if (pwdata[`SPCR_MB_ID_LSB +: 8] >= `SPCR_MB_ID_MIN && pwdata[`SPCR_MB_ID_LSB +: 8] <= `SPCR_MB_ID_MAX)
          begin
            s_d.mb_id = pwdata[`SPCR_MB_ID_LSB +: 8];
          end
          s_d.mb_baud = pwdata[`SPCR_MB_BAUD_LSB +: 3];
          if (pwdata[`SPCR_MB_PAR_LSB +: 2] != 2'h3)
          begin
            s_d.mb_par = spcr_pkg::spcr_par_t'(pwdata[`SPCR_MB_PAR_LSB +: 2]);
          end
          s_d.mb_stop2 = pwdata[`SPCR_MB_STOP_BIT];
        end
        `SPCR_OFF_RELAY:
        begin
          s_d.relay_src = spcr_pkg::spcr_src_t'(pwdata[3:0]);
        end
        `SPCR_OFF_STATUS:
        begin
          if (pwdata[0])
          begin
            s_d.queue_ovf = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    if (rd)
    begin
      s_d.prdata = 32'h0;
      unique case (paddr)
        `SPCR_OFF_PORT:   s_d.prdata = {23'h0, s_q.line_terminator, 1'b0, s_q.baud, 2'h0, s_q.mode};
        `SPCR_OFF_ADDR:   s_d.prdata = {24'h0, s_q.bus_addr};
        `SPCR_OFF_MB:     s_d.prdata = {17'h0, s_q.mb_stop2, s_q.mb_par, 1'b0, s_q.mb_baud, s_q.mb_id};
        `SPCR_OFF_RELAY:  s_d.prdata = {28'h0, s_q.relay_src};
        `SPCR_OFF_EVENTS: s_d.prdata = {22'h0, ev};
        `SPCR_OFF_STATUS: s_d.prdata = {14'h0, s_q.queue, s_q.relay, s_q.queue_ovf};
        default:          s_d.prdata = 32'h0;
      endcase
    end

    // Pulse queue: saturating count, drained one pulse per output period
    unique case (s_q.pls)
      spcr_pkg::SPCR_PLS_IDLE:
      begin
        s_d.pulse_out = 1'b0;
        if (s_q.queue != 16'h0 || pulse_edge)
        begin
          s_d.pls       = spcr_pkg::SPCR_PLS_HIGH;
          s_d.pls_cnt   = 25'h0;
          s_d.pulse_out = 1'b1;
          if (!pulse_edge)
          begin
            s_d.queue = s_q.queue - 16'h1;
          end
        end
        else if (pulse_edge)
        begin
          s_d.queue = s_q.queue;
        end
      end
      spcr_pkg::SPCR_PLS_HIGH:
      begin
        s_d.pls_cnt = s_q.pls_cnt + 25'h1;
        if (s_q.pls_cnt == (PULSE_CYC >> 1) - 25'h1)
        begin
          s_d.pls       = spcr_pkg::SPCR_PLS_GAP;
          s_d.pulse_out = 1'b0;
        end
      end
      spcr_pkg::SPCR_PLS_GAP:
      begin
        s_d.pls_cnt = s_q.pls_cnt + 25'h1;
        if (s_q.pls_cnt == PULSE_CYC - 25'h1)
        begin
          s_d.pls = spcr_pkg::SPCR_PLS_IDLE;
        end
      end
      default:
      begin
        s_d.pls = spcr_pkg::SPCR_PLS_IDLE;
      end
    endcase

    // Request during a busy output goes to the queue; overflow flag set wins over clear
    if (pulse_edge && s_q.pls != spcr_pkg::SPCR_PLS_IDLE)
    begin
      if (s_q.queue == `SPCR_QUEUE_MAX)
      begin
        s_d.queue_ovf = 1'b1;
      end
      else
      begin
        s_d.queue = s_q.queue + 16'h1;
      end
    end

    unique case (s_q.relay_src)
      spcr_pkg::SPCR_SRC_OFF:    s_d.relay = 1'b0;
      spcr_pkg::SPCR_SRC_FLO_LO: s_d.relay = ev.flow_lo;
      spcr_pkg::SPCR_SRC_FLO_HI: s_d.relay = ev.flow_hi;
      spcr_pkg::SPCR_SRC_FLO_IN: s_d.relay = flo_in;
      spcr_pkg::SPCR_SRC_PRS_LO: s_d.relay = ev.prs_lo;
      spcr_pkg::SPCR_SRC_PRS_HI: s_d.relay = ev.prs_hi;
      spcr_pkg::SPCR_SRC_PRS_IN: s_d.relay = prs_in;
      spcr_pkg::SPCR_SRC_TMP_LO: s_d.relay = ev.tmp_lo;
      spcr_pkg::SPCR_SRC_TMP_HI: s_d.relay = ev.tmp_hi;
      spcr_pkg::SPCR_SRC_TMP_IN: s_d.relay = tmp_in;
      spcr_pkg::SPCR_SRC_TOT1:   s_d.relay = ev.first_totalizer_limit;
      spcr_pkg::SPCR_SRC_TOT2:   s_d.relay = ev.second_totalizer_limit;
      spcr_pkg::SPCR_SRC_PULSE:  s_d.relay = s_q.queue_ovf;
      spcr_pkg::SPCR_SRC_ALARM:  s_d.relay = any_alarm;
      spcr_pkg::SPCR_SRC_DIAG:   s_d.relay = ev.diag;
      spcr_pkg::SPCR_SRC_MANUAL: s_d.relay = 1'b1;
    endcase

    // Address filter for frames handed up by the receiver
    s_d.dec = '0;
    if (cmd.valid)
    begin
      unique case (s_q.mode)
        spcr_pkg::SPCR_MODE_P2P:
        begin
          s_d.dec = '{execute: 1'b1, reply: 1'b1};
        end
        spcr_pkg::SPCR_MODE_BUS:
        begin
          if (cmd.addr == `SPCR_BROADCAST)
          begin
            s_d.dec = '{execute: 1'b1, reply: 1'b0};
          end
          else if (cmd.addr == s_q.bus_addr)
          begin
            s_d.dec = '{execute: 1'b1, reply: 1'b1};
          end
        end
        default:
        begin
          s_d.dec = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q                 <= '0;
      s_q.mode            <= spcr_pkg::spcr_mode_t'(`SPCR_RST_MODE);
      s_q.baud            <= `SPCR_RST_BAUD;
      s_q.bus_addr        <= `SPCR_RST_BUS_ADDR;
      s_q.line_terminator <= `SPCR_RST_TERM;
      s_q.mb_id           <= `SPCR_RST_MB_ID;
      s_q.mb_baud         <= `SPCR_RST_BAUD;
      s_q.mb_par          <= spcr_pkg::spcr_par_t'(`SPCR_RST_MB_PAR);
      s_q.mb_stop2        <= `SPCR_RST_MB_STOP;
      s_q.relay_src       <= spcr_pkg::spcr_src_t'(`SPCR_RST_RELAY);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata                    = s_q.prdata;
  assign pready                    = 1'b1;
  assign pslverr                   = psel && penable && !hit;
  assign cmd_execute               = s_q.dec.execute;
  assign cmd_reply                 = s_q.dec.reply;
  assign mb_rtu_only               = 1'b1;
  assign port_mode                 = s_q.mode;
  assign port_baud                 = s_q.baud;
  assign line_terminator           = s_q.line_terminator;
  assign mb_id                     = s_q.mb_id;
  assign mb_baud                   = s_q.mb_baud;
  assign mb_parity                 = s_q.mb_par;
  assign mb_stop2                  = s_q.mb_stop2;
  assign solid_state_switch_output = s_q.pulse_out | s_q.relay;

endmodule
